// ---- design/io_process_image_packer.sv ----
// Cyclic process image framer for the eight-port sensor gateway.
// How it works
// - Startup parameter entries from the master are stored and applied at configure.
// - With validation on, attached device identity is compared; mismatch is reported.
// - Digital image carries input and output states of switch and aux pins.
// - Port packing: byte 0 ports one to four, switch even bit, aux odd.
// - Pin packing: byte 0 switch pins, byte 1 aux pins, ports one to eight.
// - Sensor-link image byte n carries process-data byte n, up to 31.
// - Per-port length is 1,2,4,8,16 or 32 bytes in, out, or both.
`timescale 1ns/10ps
`include "io_image_regs.svh"
module io_process_image_packer
    import io_image_pkg::*;
#(
    parameter int NUM_PORTS = `IMG_NUM_PORTS,
    parameter int MAX_PD = `IMG_MAX_PD_BYTES
)
(
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // Startup parameter entry from the master.
    input wire logic param_valid_in,
    input wire logic [2:0] param_port_in,
    input wire logic [31:0] param_ident_in,
    input wire logic param_validate_in,
    input wire logic param_pin_based_in,
    input wire logic param_apply_in,
    // Attached device identity seen on each port.
    input wire logic [NUM_PORTS*32-1:0] attached_ident_in,
    // Digital pin states.
    input wire logic [7:0] switch_in_in,
    input wire logic [7:0] aux_in_in,
    // Sensor-link input process data, byte n of port p at p*MAX_PD+n.
    input wire logic [NUM_PORTS*MAX_PD*8-1:0] link_pd_in,
    // Image request from the master.
    input wire logic cycle_start_in,
    // Output image from the master.
    input wire logic out_byte_valid_in,
    input wire logic [7:0] out_byte_in,
    // Input image stream to the master.
    output logic img_valid_out,
    output logic img_last_out,
    output logic [7:0] img_byte_out,
    // Digital outputs and sensor-link output data.
    output logic [7:0] switch_out_out,
    output logic [7:0] aux_out_out,
    output logic link_out_valid_out,
    output logic [2:0] link_out_port_out,
    output logic [4:0] link_out_index_out,
    output logic [7:0] link_out_byte_out,
    // Validation status.
    output logic [7:0] ident_mismatch_out,
    output logic config_applied_out
);
    ////////////////////////////////////////////////////////////////////
    // Startup parameter staging and applied configuration.
    logic [31:0] stage_ident [8];
    logic [7:0] stage_validate;
    logic stage_pin_based;
    logic [31:0] cfg_ident [8];
    logic [7:0] cfg_validate;
    logic cfg_pin_based;

    // Sizes are powers of two from 1 to 32; any other code gives zero.
    function automatic logic [5:0] len_bytes(input logic [7:0] f);
        return (f[7:6] == 2'h0 && f != 8'h00 && (f & (f - 8'h01)) == 8'h00)
            ? f[5:0] : 6'h00;
    endfunction

    // Both length bytes must be a valid size or zero, or the digital
    // codes would be mistaken for link ports with a few input bytes.
    function automatic logic is_link(input logic [31:0] id);
        return id[31:16] == 16'h0000 && id[15:0] != 16'h0000 &&
            (id[15:8] == 8'h00 || len_bytes(id[15:8]) != 6'h00) &&
            (id[7:0] == 8'h00 || len_bytes(id[7:0]) != 6'h00);
    endfunction

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < 8; i++) begin
                stage_ident[i] <= `IMG_IDENT_SLOT_EMPTY;
            end
            stage_validate <= 8'h00;
            stage_pin_based <= `IMG_RST_PACK;
        end else if (param_valid_in) begin
            stage_ident[param_port_in] <= param_ident_in;
            stage_validate[param_port_in] <= param_validate_in;
            stage_pin_based <= param_pin_based_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < 8; i++) begin
                cfg_ident[i] <= `IMG_IDENT_SLOT_EMPTY;
            end
            cfg_validate <= 8'h00;
            cfg_pin_based <= `IMG_RST_PACK;
            config_applied_out <= 1'b0;
        end else begin
            config_applied_out <= 1'b0;
            if (param_apply_in) begin
                // Applied as a block so every port and the packing mode change in the same cycle.
                for (int i = 0; i < 8; i++) begin
                    cfg_ident[i] <= stage_ident[i];
                end
                cfg_validate <= stage_validate;
                cfg_pin_based <= stage_pin_based;
                config_applied_out <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Device validation.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ident_mismatch_out <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                ident_mismatch_out[i] <= cfg_validate[i] &&
                    attached_ident_in[i*32 +: 32] != cfg_ident[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Input image framing: two digital bytes then each link port with input bytes, in order.
    logic [15:0] dig_packed;
    digital_packer u_dig (
        .pin_based_in(cfg_pin_based),
        .switch_pins_in(switch_in_in),
        .aux_pins_in(aux_in_in),
        .packed_out(dig_packed)
    );

    frame_state_t state;
    logic [3:0] port_idx;
    logic [5:0] byte_idx;
    logic [15:0] dig_hold;

    function automatic logic [5:0] in_len(input logic [31:0] id);
        return is_link(id) ? len_bytes(id[7:0]) : 6'h00;
    endfunction

    // Finds the next port at or after p whose length in lens is nonzero; 8 if none.
    function automatic logic [3:0] next_port(input logic [3:0] p,
                                             input logic [5:0] lens [8]);
        logic [3:0] r;
        r = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (i >= p && lens[i] != 6'h00) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    logic [5:0] lens [8];
    logic [5:0] olens [8];
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lens[i] = in_len(cfg_ident[i]);
            olens[i] = is_link(cfg_ident[i]) ?
                len_bytes(cfg_ident[i][15:8]) : 6'h00;
        end
    end

    logic [3:0] next_port_idx;
    logic [5:0] next_byte_idx;
    logic load_last;
    always_comb begin
        next_port_idx = port_idx;
        next_byte_idx = byte_idx + 6'h01;
        if (port_idx == 4'hF) begin
            if (byte_idx == 6'h01) begin
                next_port_idx = next_port(4'h0, lens);
                next_byte_idx = 6'h00;
            end
        end else if (byte_idx + 6'h01 >= lens[port_idx[2:0]]) begin
            next_port_idx = next_port(port_idx + 4'h1, lens);
            next_byte_idx = 6'h00;
        end
        if (port_idx == 4'hF && byte_idx == 6'h00) begin
            load_last = next_port(4'h0, lens) == 4'h8;
        end else begin
            load_last = next_byte_idx + 6'h01 >= lens[next_port_idx[2:0]] &&
                next_port(next_port_idx + 4'h1, lens) == 4'h8;
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= ST_IDLE;
            port_idx <= 4'hF;
            byte_idx <= 6'h00;
            dig_hold <= 16'h0000;
            img_valid_out <= 1'b0;
            img_last_out <= 1'b0;
            img_byte_out <= 8'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    img_valid_out <= 1'b0;
                    img_last_out <= 1'b0;
                    if (cycle_start_in) begin
                        // Snapshot keeps both digital bytes coherent.
                        dig_hold <= dig_packed;
                        img_valid_out <= 1'b1;
                        img_byte_out <= dig_packed[7:0];
                        port_idx <= 4'hF;
                        byte_idx <= 6'h00;
                        state <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    port_idx <= next_port_idx;
                    byte_idx <= next_byte_idx;
                    img_last_out <= load_last;
                    if (load_last) begin
                        state <= ST_LAST;
                    end
                    if (port_idx == 4'hF && byte_idx == 6'h00) begin
                        img_byte_out <= dig_hold[15:8];
                    end else begin
                        img_byte_out <= link_pd_in[(32'(next_port_idx[2:0])
                            * MAX_PD + 32'(next_byte_idx)) * 8 +: 8];
                    end
                end
                ST_LAST: begin
                    img_valid_out <= 1'b0;
                    img_last_out <= 1'b0;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output image: two digital bytes, then link output bytes by port.
    logic [9:0] out_pos;
    logic [3:0] oport;
    logic [5:0] obyte;
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            out_pos <= 10'h000;
            oport <= 4'h8;
            obyte <= 6'h00;
            switch_out_out <= 8'h00;
            aux_out_out <= 8'h00;
            link_out_valid_out <= 1'b0;
            link_out_port_out <= 3'h0;
            link_out_index_out <= 5'h00;
            link_out_byte_out <= 8'h00;
        end else begin
            link_out_valid_out <= 1'b0;
            if (cycle_start_in) begin
                out_pos <= 10'h000;
                oport <= next_port(4'h0, olens);
                obyte <= 6'h00;
            end else if (out_byte_valid_in) begin
                out_pos <= out_pos + 10'h001;
                if (out_pos == 10'h000) begin
                    for (int p = 0; p < 8; p++) begin
                        if (cfg_pin_based) begin
                            switch_out_out[p] <= out_byte_in[p];
                        end else if (p < 4) begin
                            switch_out_out[p] <= out_byte_in[2*p];
                            aux_out_out[p] <= out_byte_in[2*p+1];
                        end
                    end
                end else if (out_pos == 10'h001) begin
                    for (int p = 0; p < 8; p++) begin
                        if (cfg_pin_based) begin
                            aux_out_out[p] <= out_byte_in[p];
                        end else if (p >= 4) begin
                            switch_out_out[p] <= out_byte_in[2*(p-4)];
                            aux_out_out[p] <= out_byte_in[2*(p-4)+1];
                        end
                    end
                end else if (oport < 4'h8) begin
                    // Ports without output bytes take no slot in the image.
                    link_out_valid_out <= 1'b1;
                    link_out_port_out <= oport[2:0];
                    link_out_index_out <= obyte[4:0];
                    link_out_byte_out <= out_byte_in;
                    if (obyte + 6'h01 >= olens[oport[2:0]]) begin
                        oport <= next_port(oport + 4'h1, olens);
                        obyte <= 6'h00;
                    end else begin
                        obyte <= obyte + 6'h01;
                    end
                end
            end
        end
    end
endmodule // io_process_image_packer

// ---- design/io_image_regs.svh ----
// Constants for the process image packer: sizes, codes and reset values.
`ifndef IO_IMAGE_REGS_SVH
`define IO_IMAGE_REGS_SVH
`define IMG_NUM_PORTS 8
`define IMG_MAX_PD_BYTES 32
`define IMG_DIG_BYTES 2
`define IMG_LEN_CODE_W 3
`define IMG_LEN_MAX_CODE 3'h5
`define IMG_IDENT_IN_LSB 0
`define IMG_IDENT_OUT_LSB 8
`define IMG_IDENT_W 32
`define IMG_IDENT_SLOT_EMPTY 32'h00002100
`define IMG_IDENT_DIG_IN 32'h00002101
`define IMG_IDENT_DIG_OUT 32'h00002102
`define IMG_FULL_IN_OUT_SIZE 32'h00002020
`define IMG_RST_LEN 3'h0
`define IMG_RST_PACK 1'h0
`endif

// ---- design/io_image_pkg.sv ----
// Types shared by the process image packer.
package io_image_pkg;
    typedef enum logic [1:0] {
        PACK_PORT = 2'h1,
        PACK_PIN = 2'h2
    } pack_mode_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_SEND = 3'h2,
        ST_LAST = 3'h4
    } frame_state_t;
endpackage

// ---- design/digital_packer.sv ----
// Packs the switch and aux pin states of eight ports into two image bytes.
`timescale 1ns/10ps
`include "io_image_regs.svh"
module digital_packer
    import io_image_pkg::*;
(
    // Mode and pin states.
    input wire logic pin_based_in,
    input wire logic [7:0] switch_pins_in,
    input wire logic [7:0] aux_pins_in,
    // Packed bytes.
    output logic [15:0] packed_out
);
    always_comb begin
        packed_out = 16'h0000;
        if (pin_based_in) begin
            packed_out[7:0] = switch_pins_in;
            packed_out[15:8] = aux_pins_in;
        end else begin
            for (int p = 0; p < 8; p++) begin
                packed_out[2*p] = switch_pins_in[p];
                packed_out[2*p+1] = aux_pins_in[p];
            end
        end
    end
endmodule // digital_packer

// ---- test/io_image_checker_properties.sv ----
// Port checks for the process image packer.
`timescale 1ns/10ps
module io_image_checker #(
    parameter int NUM_PORTS = 8,
    parameter int MAX_PD = 32
)
(
    // Clock, reset and master side.
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic param_valid_in,
    input wire logic param_pin_based_in,
    input wire logic param_apply_in,
    input wire logic cycle_start_in,
    input wire logic out_byte_valid_in,
    input wire logic [7:0] switch_in_in,
    input wire logic [7:0] aux_in_in,
    // Device side.
    input wire logic img_valid_out,
    input wire logic img_last_out,
    input wire logic [7:0] img_byte_out,
    input wire logic link_out_valid_out,
    input wire logic config_applied_out
);
    logic pin_stage;
    logic pin_live;
    logic [15:0] port_img;
    // The mode only counts once applied, so the staged copy is tracked too.
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_stage <= 1'h0;
            pin_live <= 1'h0;
        end else begin
            if (param_valid_in)
                pin_stage <= param_pin_based_in;
            if (param_apply_in)
                pin_live <= pin_stage;
        end
    end
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            port_img[2*k] = switch_in_in[k];
            port_img[2*k+1] = aux_in_in[k];
        end
    end
    default clocking dc @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    a_start_answer: assert property (
        $rose(img_valid_out) |-> $past(cycle_start_in)) else $error("start");
    a_min_frame: assert property (
        $rose(img_valid_out) |-> !img_last_out) else $error("short frame");
    a_last_valid: assert property (
        img_last_out |-> img_valid_out) else $error("last alone");
    a_idle_after_last: assert property (
        img_last_out |=> !img_valid_out [*2]) else $error("no gap");
    a_valid_holds: assert property (
        img_valid_out && !img_last_out |=> img_valid_out) else $error("gap");
    a_port_pack: assert property (
        $rose(img_valid_out) && !pin_live |-> img_byte_out ==
        $past(port_img[7:0]) ##1 img_byte_out == $past(port_img[15:8], 2))
        else $error("port packing");
    a_pin_pack: assert property (
        $rose(img_valid_out) && pin_live |-> img_byte_out ==
        $past(switch_in_in) ##1 img_byte_out == $past(aux_in_in, 2))
        else $error("pin packing");
    a_link_lag: assert property (
        link_out_valid_out |-> $past(out_byte_valid_in)) else $error("lag");
    a_apply_pulse: assert property (
        config_applied_out |-> $past(param_apply_in) ##1 !config_applied_out)
        else $error("apply pulse");
    cover property (img_last_out);
    cover property (link_out_valid_out);
    cover property ($rose(img_valid_out) && pin_live);
endmodule // io_image_checker
bind io_process_image_packer io_image_checker #(
    .NUM_PORTS(NUM_PORTS),
    .MAX_PD(MAX_PD)
) u_chk (
    .sys_clk_in, .resetn_in, .param_valid_in, .param_pin_based_in,
    .param_apply_in, .cycle_start_in, .out_byte_valid_in, .switch_in_in,
    .aux_in_in, .img_valid_out, .img_last_out, .img_byte_out,
    .link_out_valid_out, .config_applied_out
);

// ---- test/fieldbus_master_model.sv ----
// Fieldbus master model: requests frames and streams the output image.
`timescale 1ns/10ps
module fieldbus_master_model (
    // Clock and input image.
    input wire logic clk_in,
    input wire logic img_valid_in,
    input wire logic img_last_in,
    input wire logic [7:0] img_byte_in,
    // Frame request and output image.
    output logic cycle_start_out,
    output logic out_byte_valid_out,
    output logic [7:0] out_byte_out
);
    logic [7:0] out_img [40];
    logic [7:0] rx [$];
    logic hung;
    initial begin
        cycle_start_out = 1'h0;
        out_byte_valid_out = 1'h0;
        out_byte_out = 8'h00;
        hung = 1'h0;
    end
    // Output bytes follow the start one per cycle; idle data is inverted
    // so a stale byte is never mistaken for a fresh one.
    task run_frame(input int n_out);
        int i;
        logic done;
        rx.delete();
        done = 1'h0;
        @(posedge clk_in);
        #1;
        cycle_start_out = 1'h1;
        for (i = 0; i < 100 && !(done && i > n_out); i++) begin
            @(posedge clk_in);
            #1;
            if (img_valid_in) begin
                rx.push_back(img_byte_in);
                done = done | img_last_in;
            end
            cycle_start_out = 1'h0;
            out_byte_valid_out = (i < n_out);
            out_byte_out = (i < n_out) ? out_img[i] : ~out_byte_out;
        end
        hung = !done;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
endmodule // fieldbus_master_model

// ---- test/tb_top.sv ----
// Self-checking bench for the process image packer.
`timescale 1ns/10ps
`include "io_image_regs.svh"
module tb_top;
    logic sys_clk_in, resetn_in, param_valid_in, param_validate_in;
    logic param_pin_based_in, param_apply_in, cycle_start_in;
    logic out_byte_valid_in, img_valid_out, img_last_out;
    logic link_out_valid_out, config_applied_out;
    logic [2:0] param_port_in, link_out_port_out;
    logic [4:0] link_out_index_out;
    logic [31:0] param_ident_in;
    logic [255:0] attached_ident_in;
    logic [2047:0] link_pd_in;
    logic [7:0] switch_in_in, aux_in_in, out_byte_in, img_byte_out;
    logic [7:0] switch_out_out, aux_out_out, link_out_byte_out;
    logic [7:0] ident_mismatch_out;
    logic [15:0] lo_q [$];
    int err_total;
    int n_checks;
    typedef struct packed {
        logic pin;
        logic [7:0] sw;
        logic [7:0] aux;
        logic [15:0] img;
    } row_t;
    row_t rows [6] = '{
        '{1'h0, 8'h01, 8'h00, 16'h0001}, '{1'h0, 8'h00, 8'h01, 16'h0002},
        '{1'h0, 8'hF0, 8'h00, 16'h5500}, '{1'h0, 8'h00, 8'h0F, 16'h00AA},
        '{1'h1, 8'hA5, 8'h3C, 16'h3CA5}, '{1'h1, 8'h01, 8'h80, 16'h8001}
    };
    io_process_image_packer u_dut (
        .sys_clk_in, .resetn_in, .param_valid_in, .param_port_in,
        .param_ident_in, .param_validate_in, .param_pin_based_in,
        .param_apply_in, .attached_ident_in, .switch_in_in, .aux_in_in,
        .link_pd_in, .cycle_start_in, .out_byte_valid_in, .out_byte_in,
        .img_valid_out, .img_last_out, .img_byte_out, .switch_out_out,
        .aux_out_out, .link_out_valid_out, .link_out_port_out,
        .link_out_index_out, .link_out_byte_out, .ident_mismatch_out,
        .config_applied_out
    );
    fieldbus_master_model u_m (
        .clk_in(sys_clk_in), .img_valid_in(img_valid_out),
        .img_last_in(img_last_out), .img_byte_in(img_byte_out),
        .cycle_start_out(cycle_start_in),
        .out_byte_valid_out(out_byte_valid_in), .out_byte_out(out_byte_in)
    );
    initial begin
        sys_clk_in = 1'h0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        if (link_out_valid_out === 1'h1)
            lo_q.push_back({link_out_port_out, link_out_index_out,
                link_out_byte_out});
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task complete_run;
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    // Stages one entry and applies it at once.
    task cfg(input logic [2:0] p, input logic [31:0] id, input logic v,
             input logic pin);
        tick(1);
        param_valid_in = 1'h1;
        param_port_in = p;
        param_ident_in = id;
        param_validate_in = v;
        param_pin_based_in = pin;
        tick(1);
        param_valid_in = 1'h0;
        param_ident_in = ~id;
        param_apply_in = 1'h1;
        tick(1);
        param_apply_in = 1'h0;
        chk(config_applied_out, 1'h1);
    endtask
    task frame(input int n);
        u_m.run_frame(n);
        if (u_m.hung) begin
            err_total++;
            complete_run();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        int k;
        int n;
        int len;
        {param_valid_in, param_validate_in, param_pin_based_in} = 3'h0;
        {param_apply_in, param_port_in, param_ident_in} = '0;
        {switch_in_in, aux_in_in, link_pd_in} = '0;
        attached_ident_in = {8{`IMG_IDENT_SLOT_EMPTY}};
        err_total = 0;
        n_checks = 0;
        resetn_in = 1'h0;
        tick(16);
        resetn_in = 1'h1;
        chk({img_valid_out, link_out_valid_out, config_applied_out,
             ident_mismatch_out, switch_out_out, aux_out_out}, 64'h0);
        for (i = 0; i < 6; i++) begin
            cfg(3'h0, `IMG_IDENT_SLOT_EMPTY, 1'h0, rows[i].pin);
            switch_in_in = rows[i].sw;
            aux_in_in = rows[i].aux;
            u_m.out_img[0] = rows[i].img[7:0];
            u_m.out_img[1] = rows[i].img[15:8];
            frame(2);
            chk(u_m.rx.size(), 2);
            chk({u_m.rx[1], u_m.rx[0]}, rows[i].img);
            chk({aux_out_out, switch_out_out},
                {rows[i].aux, rows[i].sw});
        end
        // Port 3 takes every length; port 8 adds one trailing byte.
        link_pd_in[1792+:8] = 8'h99;
        for (n = 0; n < 32; n++) begin
            link_pd_in[(64+n)*8+:8] = 8'h40 + n[7:0];
            u_m.out_img[2+n] = 8'hC0 + n[7:0];
        end
        cfg(3'h7, 32'h00000001, 1'h0, 1'h0);
        for (k = 0; k < 6; k++) begin
            len = 1 << k;
            cfg(3'h2, {16'h0, len[7:0], len[7:0]}, 1'h0, 1'h0);
            lo_q.delete();
            frame(2 + len);
            chk(u_m.rx.size(), 3 + len);
            chk(lo_q.size(), len);
            chk(u_m.rx[2+len], 8'h99);
            for (n = 0; n < len; n++) begin
                chk(u_m.rx[2+n], 8'h40 + n[7:0]);
                chk(lo_q[n], {3'h2, n[4:0], 8'hC0 + n[7:0]});
            end
        end
        cfg(3'h2, `IMG_FULL_IN_OUT_SIZE, 1'h1, 1'h0);
        tick(3);
        chk(ident_mismatch_out, 8'h04);
        attached_ident_in[64+:32] = `IMG_FULL_IN_OUT_SIZE;
        tick(3);
        chk(ident_mismatch_out, 8'h00);
        // A digital code on port 1 must add no link bytes to the image.
        cfg(3'h0, `IMG_IDENT_DIG_OUT, 1'h0, 1'h0);
        frame(2);
        chk(u_m.rx.size(), 35);
        complete_run();
    end
endmodule // tb_top
